// *** ires_cfg.svh ***
`ifndef IRES_CFG_SVH
`define IRES_CFG_SVH
// register word offsets (byte address on the plain port)
`define IRES_OFS_ID          8'h00
`define IRES_OFS_CTX_TAG     8'h04
`define IRES_OFS_STATUS      8'h08
`define IRES_OFS_SYND0       8'h0c
`define IRES_OFS_SYND1_LO    8'h10
`define IRES_OFS_SYND1_HI    8'h14
`define IRES_OFS_DOM_SEL     8'h18
`define IRES_OFS_TBL_VALID   8'h1c
// status field positions
`define IRES_ST_VALID        0
`define IRES_ST_MULTI        1
`define IRES_ST_S0V          2
`define IRES_ST_S1V          3
`define IRES_ST_FC_LSB       8
`define IRES_ST_IFC_LSB      16
// id register field positions
`define IRES_ID_SWE          0
`define IRES_ID_REALM        1
// reset values
`define IRES_CTX_TAG_RST     16'h0000
`define IRES_SEL_RST         2'h0
`endif

// *** ires_err_capture.sv ***
`default_nettype none
`include "ires_cfg.svh"
// one error capture set for a single interrupt domain
module ires_err_capture
    import ires_pkg::*;
#(
    parameter int FC_W   = 8,
    parameter int IFC_W  = 8,
    parameter int SYN0_W = 32,
    parameter int ADDR_W = 48
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // error report
    input  wire logic              i_err,
    input  wire logic              i_impl,
    input  wire logic [FC_W-1:0]   i_fc,
    input  wire logic              i_s0v,
    input  wire logic              i_s1v,
    input  wire logic [SYN0_W-1:0] i_syn0,
    input  wire logic [ADDR_W-1:0] i_addr,
    // write-one-to-clear
    input  wire logic              i_clr_valid,
    input  wire logic              i_clr_multi,
    // captured state
    output logic                   o_valid,
    output logic                   o_multi,
    output logic                   o_s0v,
    output logic                   o_s1v,
    output logic [FC_W-1:0]        o_fc,
    output logic [IFC_W-1:0]       o_ifc,
    output logic [SYN0_W-1:0]      o_syn0,
    output logic [ADDR_W-1:0]      o_addr
);
    logic capture;
    assign capture = i_err && (!o_valid || i_clr_valid);

    // valid: new error wins over a clear in the same cycle
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else if (i_err) begin
            o_valid <= 1'b1;
        end else if (i_clr_valid) begin
            o_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_multi <= 1'b0;
        end else if (i_err && o_valid && !i_clr_valid) begin
            o_multi <= 1'b1;
        end else if (i_clr_multi) begin
            o_multi <= 1'b0;
        end
    end

    // held payload is frozen while valid, so the first error is kept
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_s0v  <= 1'b0;
            o_s1v  <= 1'b0;
            o_fc   <= '0;
            o_ifc  <= '0;
            o_syn0 <= '0;
            o_addr <= '0;
        end else if (capture) begin
            o_s0v  <= i_s0v;
            o_s1v  <= i_s1v;
            o_fc   <= i_impl ? '0 : i_fc;
            o_ifc  <= i_impl ? IFC_W'(i_fc) : '0;
            o_syn0 <= i_syn0;
            o_addr <= i_addr;
        end
    end

    held_payload_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_valid && !i_clr_valid |=> $stable(o_fc) && $stable(o_syn0))
        else $error("payload changed while error held");
    multi_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_err && o_valid && !i_clr_valid |=> o_multi)
        else $error("second error did not set multi flag");
    set_wins_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_err |=> o_valid)
        else $error("error not captured");
    impl_zero_fc_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        capture && i_impl |=> o_fc == '0)
        else $error("fault code not zero on impl error");
    synd_flags_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        capture |=> o_s0v == $past(i_s0v) && o_s1v == $past(i_s1v))
        else $error("syndrome valid flags not captured");
    synd_payload_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        capture |=> o_syn0 == $past(i_syn0) && o_addr == $past(i_addr))
        else $error("syndrome payload not captured");
    multi_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_clr_multi && !i_err |=> !o_multi)
        else $error("multi flag not cleared");
    cov_multi: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        o_valid ##1 o_multi);
endmodule
`default_nettype wire

// *** ires_mem_model.sv ***
`default_nettype none
// ****************************************
// memory system seen by the tagged accesses
// ****************************************
module ires_mem_model
    import ires_pkg::*;
#(
    parameter int         ADDR_W   = 48,
    parameter logic [7:0] ABORT_FC = 8'h21
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // tagged access from the block
    input  wire logic              i_req,
    input  wire ires_pas_t         i_pas,
    input  wire logic [ADDR_W-1:0] i_addr,
    // bench order to fail every access made while it is held high
    input  wire logic              i_fail,
    // write-back abort toward the block
    output logic                   o_abort,
    output logic [1:0]             o_dom,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [7:0]             o_fc
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_abort <= 1'b0;
            o_dom   <= 2'h0;
            o_addr  <= '0;
            o_fc    <= 8'h00;
        end else if (i_req && i_fail) begin
            o_abort <= 1'b1;
            o_dom   <= i_pas;
            o_addr  <= i_addr;
            o_fc    <= ABORT_FC;
        end else begin
            // qualifiers no longer hold: toggle so stale values cannot pass
            o_abort <= 1'b0;
            o_dom   <= ~o_dom;
            o_addr  <= ~o_addr;
            o_fc    <= ~o_fc;
        end
    end
endmodule
`default_nettype wire

// *** ires_pkg.sv ***
`default_nettype none
package ires_pkg;
    typedef enum logic [1:0] {
        IRES_PAS_SECURE,
        IRES_PAS_NONSECURE,
        IRES_PAS_ROOT,
        IRES_PAS_REALM
    } ires_pas_t;
    typedef enum logic [1:0] {
        IRES_SRC_EVENT,
        IRES_SRC_SYSREG,
        IRES_SRC_SYSINSN,
        IRES_SRC_MMIO
    } ires_src_t;
endpackage
`default_nettype wire

// *** ires_top.sv ***
`default_nettype none
`include "ires_cfg.svh"
module ires_top
    import ires_pkg::*;
#(
    parameter int  N_DOM     = 4,
    parameter int  TAG_W     = 16,
    parameter int  ADDR_W    = 48,
    parameter int  FC_W      = 8,
    parameter int  IFC_W     = 8,
    parameter int  INTID_W   = 24,
    parameter int  TYPE_W    = 3,
    parameter bit  HAS_SWE   = 1'b1,
    parameter bit  HAS_REALM = 1'b1
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // register port
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic [31:0]            o_reg_rdata,
    // memory access request from the service core
    input  wire logic              i_mem_req,
    input  wire ires_pas_t         i_mem_pas,
    input  wire logic [ADDR_W-1:0] i_mem_addr,
    // memory access toward the memory system
    output logic                   o_mem_req,
    output ires_pas_t              o_mem_pas,
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic [TAG_W-1:0]       o_mem_ctx_tag,
    // detected programming error
    input  wire logic              i_err,
    input  wire logic [1:0]        i_err_dom,
    input  wire ires_src_t         i_err_src,
    input  wire logic              i_err_impl,
    input  wire logic [FC_W-1:0]   i_err_fc,
    input  wire logic              i_err_s0v,
    input  wire logic              i_err_s1v,
    input  wire logic [TYPE_W-1:0] i_err_int_type,
    input  wire logic [INTID_W-1:0] i_err_int_id,
    input  wire logic              i_err_virt,
    input  wire logic [ADDR_W-1:0] i_err_addr,
    // write-back external abort from the memory system
    input  wire logic              i_wb_abort,
    input  wire logic [1:0]        i_wb_dom,
    input  wire logic [ADDR_W-1:0] i_wb_addr,
    input  wire logic [FC_W-1:0]   i_wb_fc,
    // table enables steered by software
    output logic                   o_state_table_base_valid,
    output logic                   o_vm_table_base_valid
);
    localparam int SYN0_W = 32;

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [TAG_W-1:0] realm_context_tag_field_r;
    logic [1:0]       dom_sel_r;
    logic             state_tbl_r;
    logic             vm_tbl_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            realm_context_tag_field_r <= `IRES_CTX_TAG_RST;
        end else if (i_reg_wr && hit(i_reg_addr, `IRES_OFS_CTX_TAG)) begin
            realm_context_tag_field_r <= i_reg_wdata[TAG_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dom_sel_r <= `IRES_SEL_RST;
        end else if (i_reg_wr && hit(i_reg_addr, `IRES_OFS_DOM_SEL)) begin
            dom_sel_r <= i_reg_wdata[1:0];
        end
    end

    // enables are software's; keeping tags aligned first is its duty
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_tbl_r <= 1'b0;
            vm_tbl_r    <= 1'b0;
        end else if (i_reg_wr && hit(i_reg_addr, `IRES_OFS_TBL_VALID)) begin
            state_tbl_r <= i_reg_wdata[0];
            vm_tbl_r    <= i_reg_wdata[1];
        end
    end
    assign o_state_table_base_valid = state_tbl_r;
    assign o_vm_table_base_valid    = vm_tbl_r;

    // ****************************************************************
    // memory access tagging
    // ****************************************************************
    logic [TAG_W-1:0] tag_nxt;
    always_comb begin
        tag_nxt = '0;
        if (HAS_REALM && i_mem_pas == IRES_PAS_REALM) begin
            tag_nxt = realm_context_tag_field_r;
        end
    end

    // space is passed unchanged: a tag mismatch never moves the access
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_mem_req     <= 1'b0;
            o_mem_pas     <= IRES_PAS_SECURE;
            o_mem_addr    <= '0;
            o_mem_ctx_tag <= '0;
        end else begin
            o_mem_req     <= i_mem_req;
            o_mem_pas     <= i_mem_pas;
            o_mem_addr    <= i_mem_addr;
            o_mem_ctx_tag <= tag_nxt;
        end
    end

    // ****************************************************************
    // per-domain error capture
    // ****************************************************************
    logic              d_valid [N_DOM];
    logic              d_multi [N_DOM];
    logic              d_s0v   [N_DOM];
    logic              d_s1v   [N_DOM];
    logic [FC_W-1:0]   d_fc    [N_DOM];
    logic [IFC_W-1:0]  d_ifc   [N_DOM];
    logic [SYN0_W-1:0] d_syn0  [N_DOM];
    logic [ADDR_W-1:0] d_addr  [N_DOM];

    // every source class reaches the same capture path
    logic sw_err;
    assign sw_err = HAS_SWE && i_err &&
                    (i_err_src inside {IRES_SRC_EVENT, IRES_SRC_SYSREG,
                                       IRES_SRC_SYSINSN, IRES_SRC_MMIO});

    logic [SYN0_W-1:0] syn0_in;
    assign syn0_in = SYN0_W'({i_err_virt, i_err_int_type, i_err_int_id});

    logic st_wr;
    assign st_wr = i_reg_wr && hit(i_reg_addr, `IRES_OFS_STATUS);

    genvar g;
    generate
        for (g = 0; g < N_DOM; g++) begin : g_dom
            logic sw_hit;
            logic wb_hit;
            logic sel;
            // abort beats a concurrent sw error: it may arrive late
            assign wb_hit = HAS_SWE && i_wb_abort && (i_wb_dom == 2'(g));
            assign sw_hit = sw_err && (i_err_dom == 2'(g)) && !wb_hit;
            assign sel    = st_wr && (dom_sel_r == 2'(g));
            ires_err_capture #(
                .FC_W   (FC_W),
                .IFC_W  (IFC_W),
                .SYN0_W (SYN0_W),
                .ADDR_W (ADDR_W)
            ) u_cap (
                .i_clk_sys   (i_clk_sys),
                .i_rst       (i_rst),
                .i_err       (sw_hit || wb_hit),
                .i_impl      (sw_hit && i_err_impl),
                .i_fc        (wb_hit ? i_wb_fc : i_err_fc),
                .i_s0v       (sw_hit && i_err_s0v),
                .i_s1v       (wb_hit || i_err_s1v),
                .i_syn0      (wb_hit ? '0 : syn0_in),
                .i_addr      (wb_hit ? i_wb_addr : i_err_addr),
                .i_clr_valid (sel && i_reg_wdata[`IRES_ST_VALID]),
                .i_clr_multi (sel && i_reg_wdata[`IRES_ST_MULTI]),
                .o_valid     (d_valid[g]),
                .o_multi     (d_multi[g]),
                .o_s0v       (d_s0v[g]),
                .o_s1v       (d_s1v[g]),
                .o_fc        (d_fc[g]),
                .o_ifc       (d_ifc[g]),
                .o_syn0      (d_syn0[g]),
                .o_addr      (d_addr[g])
            );
        end
    endgenerate

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [31:0] rd_nxt;
    logic [63:0] addr_ext;
    always_comb begin
        rd_nxt   = '0;
        addr_ext = 64'(d_addr[dom_sel_r]);
        unique case (i_reg_addr)
            `IRES_OFS_ID: begin
                rd_nxt[`IRES_ID_SWE]   = HAS_SWE;
                rd_nxt[`IRES_ID_REALM] = HAS_REALM;
            end
            `IRES_OFS_CTX_TAG: rd_nxt = 32'(realm_context_tag_field_r);
            `IRES_OFS_STATUS: begin
                rd_nxt[`IRES_ST_VALID] = d_valid[dom_sel_r];
                rd_nxt[`IRES_ST_MULTI] = d_multi[dom_sel_r];
                rd_nxt[`IRES_ST_S0V]   = d_s0v[dom_sel_r];
                rd_nxt[`IRES_ST_S1V]   = d_s1v[dom_sel_r];
                rd_nxt[`IRES_ST_FC_LSB +: FC_W]   = d_fc[dom_sel_r];
                rd_nxt[`IRES_ST_IFC_LSB +: IFC_W] = d_ifc[dom_sel_r];
            end
            `IRES_OFS_SYND0:    rd_nxt = d_syn0[dom_sel_r];
            `IRES_OFS_SYND1_LO: rd_nxt = addr_ext[31:0];
            `IRES_OFS_SYND1_HI: rd_nxt = addr_ext[63:32];
            `IRES_OFS_DOM_SEL:  rd_nxt = 32'(dom_sel_r);
            `IRES_OFS_TBL_VALID: rd_nxt = {30'h0, vm_tbl_r, state_tbl_r};
            default:            rd_nxt = '0;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= i_reg_rd ? rd_nxt : '0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    nonrealm_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_mem_req && i_mem_pas != IRES_PAS_REALM |=> o_mem_ctx_tag == '0)
        else $error("non-realm access carried nonzero tag");
    realm_tag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_mem_req && i_mem_pas == IRES_PAS_REALM && HAS_REALM
        |=> o_mem_ctx_tag == $past(realm_context_tag_field_r))
        else $error("realm access tag differs from field");
    no_realm_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !HAS_REALM |-> o_mem_ctx_tag == '0)
        else $error("tag nonzero without realm support");
    pas_kept_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_mem_req |=> o_mem_req && o_mem_pas == $past(i_mem_pas))
        else $error("access space changed");
    abort_reported_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        HAS_SWE && i_wb_abort |=> d_valid[$past(i_wb_dom)])
        else $error("write-back abort not captured");
    swe_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_reg_rd && i_reg_addr == `IRES_OFS_ID |=> o_reg_rdata[`IRES_ID_SWE] == HAS_SWE)
        else $error("support flag wrong");
    clear_works_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        st_wr && i_reg_wdata[`IRES_ST_VALID] && !i_err && !i_wb_abort
        |=> !d_valid[$past(dom_sel_r)])
        else $error("status clear ignored");
    rd_one_cycle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_reg_rd |=> o_reg_rdata == '0)
        else $error("read data outside read slot");

    cov_realm: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_mem_req && i_mem_pas == IRES_PAS_REALM);
    cov_abort: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_wb_abort);
    cov_clear: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        st_wr ##1 i_reg_rd);
endmodule
`default_nettype wire

// *** ires_top_tb.sv ***
`default_nettype none
module ires_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ires_pkg::*;
    localparam logic [7:0] ABT_FC = 8'h21;
    logic        clk, rst, wr, rd, mreq, oreq, err, eimp, es0, es1, evirt, wab, stv, vmv, fail_en;
    logic [7:0]  ra, efc, wfc, x_fc;
    logic [31:0] rw, rdata, v;
    logic [47:0] maddr, oaddr, eaddr, waddr, x_ad, a;
    logic [15:0] otag, tag;
    logic [1:0]  edom, wdom;
    logic [2:0]  etyp;
    logic [23:0] eid;
    ires_pas_t   mpas, opas;
    ires_src_t   esrc;
    logic [31:0] syn_q [4];
    logic [47:0] ad_q [4];
    logic [7:0]  fc_q [4];
    int          fails, samples_checked;

    ires_top i_ires_top (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rw),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_mem_req(mreq), .i_mem_pas(mpas),
        .i_mem_addr(maddr), .o_mem_req(oreq), .o_mem_pas(opas), .o_mem_addr(oaddr),
        .o_mem_ctx_tag(otag), .i_err(err), .i_err_dom(edom), .i_err_src(esrc),
        .i_err_impl(eimp), .i_err_fc(efc), .i_err_s0v(es0), .i_err_s1v(es1),
        .i_err_int_type(etyp), .i_err_int_id(eid), .i_err_virt(evirt), .i_err_addr(eaddr),
        .i_wb_abort(wab), .i_wb_dom(wdom), .i_wb_addr(waddr), .i_wb_fc(wfc),
        .o_state_table_base_valid(stv), .o_vm_table_base_valid(vmv));
    ires_mem_model #(.ABORT_FC(ABT_FC)) i_ires_mem_model (.i_clk_sys(clk), .i_rst(rst),
        .i_req(oreq), .i_pas(opas), .i_addr(oaddr), .i_fail(fail_en), .o_abort(wab),
        .o_dom(wdom), .o_addr(waddr), .o_fc(wfc));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // checks and bus cycles
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        ra <= ad;
        rw <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk);
        ra <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_dom(input logic [1:0] dm, input logic [7:0] ad, output logic [31:0] d);
        wr_reg(8'h18, {30'h0, dm});
        rd_reg(ad, d);
    endtask
    function automatic logic [31:0] st_exp(input logic m, s0, s1, input logic [7:0] f, i);
        return {8'h00, i, f, 4'h0, s1, s0, m, 1'b1};
    endfunction
    task automatic mem_xfer(input ires_pas_t p, input logic [47:0] ad);
        @(posedge clk);
        mreq  <= 1'b1;
        mpas  <= p;
        maddr <= ad;
        @(posedge clk);
        mreq <= 1'b0;
        #1;
        chk("mem_req", 1'b1, oreq);
        chk("mem_tag", (p == IRES_PAS_REALM) ? tag : 16'h0, otag);
        chk("mem_pas", p, opas);
        chk("mem_addr", ad, oaddr);
    endtask
    task automatic fire(input logic [1:0] dm, input logic imp);
        x_fc = $urandom;
        x_ad = {$urandom, $urandom};
        @(posedge clk);
        {err, edom, eimp, efc, es0, es1, eaddr} <= {1'b1, dm, imp, x_fc, 2'b11, x_ad};
        {etyp, eid, evirt} <= $urandom;
        @(posedge clk);
        err <= 1'b0;
        #1 syn_q[dm] = {4'h0, evirt, etyp, eid};
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst, wr, rd, mreq, err, eimp, es0, es1, evirt, fail_en} = 10'h200;
        {ra, rw, maddr, edom, efc, etyp, eid, eaddr} = '0;
        mpas = IRES_PAS_SECURE;
        esrc = IRES_SRC_EVENT;
        fails = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(50140));
        for (int d = 0; d < 4; d++) begin
            rd_dom(d[1:0], 8'h00, v);
            chk("id_flags", 2'h3, v[1:0]);
        end
        wr_reg(8'h00, 32'h0);
        rd_reg(8'h00, v);
        chk("id_readonly", 1'b1, v[0]);
        rd_reg(8'h40, v);
        chk("unmapped", 32'h0, v);
        tag = $urandom;
        wr_reg(8'h04, {16'h0, tag});
        for (int i = 0; i < 12; i++) mem_xfer(ires_pas_t'(i % 4), {$urandom, $urandom});
        // one error per domain, each from a different source
        for (int d = 0; d < 4; d++) begin
            esrc <= ires_src_t'(d);
            fire(d[1:0], 1'b0);
            fc_q[d] = x_fc;
            ad_q[d] = x_ad;
        end
        for (int d = 0; d < 4; d++) begin
            rd_dom(d[1:0], 8'h08, v);
            chk("status", st_exp(0, 1, 1, fc_q[d], 0), v & 32'h00ffff0f);
            rd_reg(8'h0c, v);
            chk("syndrome0", syn_q[d], v & 32'h0fffffff);
            rd_reg(8'h10, v);
            chk("syndrome1_lo", ad_q[d][31:0], v);
            rd_reg(8'h14, v);
            chk("syndrome1_hi", ad_q[d][47:32], v);
        end
        // a second error must not overwrite the held one
        fire(2'h1, 1'b0);
        rd_dom(2'h1, 8'h08, v);
        chk("multi", st_exp(1, 1, 1, fc_q[1], 0), v & 32'h00ffff0f);
        wr_reg(8'h08, 32'h3);
        rd_reg(8'h08, v);
        chk("cleared", 2'h0, v[1:0]);
        rd_dom(2'h2, 8'h08, v);
        chk("other_dom", 1'b1, v[0]);
        fire(2'h1, 1'b1);
        rd_dom(2'h1, 8'h08, v);
        chk("impl", st_exp(0, 1, 1, 8'h00, x_fc), v & 32'h00ffff0f);
        // write-back abort raised by the memory model on a failed realm access
        wr_reg(8'h18, 32'h3);
        wr_reg(8'h08, 32'h3);
        rd_reg(8'h08, v);
        chk("pre_abort", 1'b0, v[0]);
        a = {$urandom, $urandom};
        fail_en <= 1'b1;
        mem_xfer(IRES_PAS_REALM, a);
        for (int k = 0; k < 10 && v[0] !== 1'b1; k++) rd_reg(8'h08, v);
        fail_en <= 1'b0;
        chk("abort", st_exp(0, 0, 1, ABT_FC, 0), v & 32'h00ffff0f);
        rd_reg(8'h10, v);
        chk("abort_lo", a[31:0], v);
        rd_reg(8'h14, v);
        chk("abort_hi", a[47:32], v);
        // software sets table valids only after the tags agree
        wr_reg(8'h1c, 32'h2);
        #1 chk("tables", 2'h2, {vmv, stv});
        wr_reg(8'h1c, 32'h1);
        #1 chk("tables", 2'h1, {vmv, stv});
        report_and_stop();
    end
endmodule
`default_nettype wire
